// file: include/pcts_pkg.sv
// pcts_pkg: register map, field layout and timing constants for the
// configuration and test support block.
// assumes a 20 MHz pclk and a 32-bit apb register bus.
package pcts_pkg;
    // register byte offsets
    localparam logic [7:0] SIG_LO_OFF = 8'h00;  // signature bits 31:0
    localparam logic [7:0] SIG_HI_OFF = 8'h04;  // signature bits 63:32
    localparam logic [7:0] CFG_OFF = 8'h08;     // functional configuration word
    localparam logic [7:0] CTRL_OFF = 8'h0c;    // program / lock control
    localparam logic [7:0] STAT_OFF = 8'h10;    // status
    localparam logic [7:0] PRELOAD_OFF = 8'h14; // preload values
    localparam logic [7:0] POL_OFF = 8'h18;     // output polarity
    localparam logic [7:0] OE_OFF = 8'h1c;      // output enables
    localparam logic [7:0] PIN_OFF = 8'h20;     // synchronised pin levels
    localparam logic [7:0] MCELL_OFF = 8'h24;   // macrocell register state
    // control register fields
    localparam int CTRL_PROG_BIT = 0;    // start programming cycle
    localparam int CTRL_LOCK_BIT = 1;    // program the security lock
    localparam int CTRL_PRELOAD_BIT = 2; // force preload at next edge
    // status fields
    localparam int STAT_LOCK_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_RSTDONE_BIT = 2;
    // value returned for configuration reads while locked
    localparam logic [31:0] LOCKED_READ_VALUE = 32'h0000_0000;
    localparam logic [31:0] SIG_RESET = 32'h0000_0000;
    // erase then write phase lengths of a programming cycle, in cycles
    localparam int ERASE_CYCLES = 8;
    localparam int WRITE_CYCLES = 8;
    // power-up reset, longest time in ns and cycle count
    localparam int TPR_NS = 1000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int TPR_CYCLES = TPR_NS / CLK_PERIOD_NS;
    // programming sequencer states
    typedef enum logic [2:0] {
        PCTS_IDLE = 3'b001,
        PCTS_ERASE = 3'b010,
        PCTS_WRITE = 3'b100
    } pcts_prog_e;
endpackage

// file: core/pcts_macrocell.sv
// pcts_macrocell: one registered output cell with polarity, preload,
// clear term and set term, both taken at the pclk edge.
// assumes all inputs already sit in the pclk domain.
`timescale 1ns/1ps
module pcts_macrocell (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic d,
    input wire logic invert,
    input wire logic preload_en,
    input wire logic preload_val,
    input wire logic async_clear_term,
    input wire logic sync_set_term,
    output logic q,
    output logic pin_level
);
    // register: clear and set act on the stored value, not the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= 1'b0;
        end else if (async_clear_term) begin
            q <= 1'b0;
        end else if (preload_en) begin
            q <= preload_val;
        end else if (sync_set_term) begin
            q <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // pin level follows programmed polarity
    assign pin_level = q ^ invert;
endmodule

// file: core/pcts_top.sv
// pcts_top: signature store, security lock, programming sequencer,
// output preload and power-up reset for a bank of registered outputs.
// assumes an apb master on pclk; pins arrive asynchronously.
`timescale 1ns/1ps
module pcts_top #(
    parameter int NOUT = 12,
    parameter int NIN = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NIN-1:0] in_pin,
    input wire logic [NIN-1:0] in_pin_driven,
    output logic [NOUT-1:0] out_pin_o,
    output logic [NOUT-1:0] out_pin_oe,
    output logic reset_done
);
    localparam int CW = $clog2(pcts_pkg::TPR_CYCLES + 1);
    localparam int PW = $clog2(pcts_pkg::ERASE_CYCLES + pcts_pkg::WRITE_CYCLES + 1);

    logic [31:0] sig_lo_r, sig_hi_r, cfg_r, stage_lo_r, stage_hi_r, stage_cfg_r;
    logic lock_r, lock_req_r, preload_r;
    logic [NOUT-1:0] preload_val_r, pol_r, oe_r, mcell_q, pin_lvl;
    logic [NIN-1:0] in_s1_r, in_s2_r, drv_s1_r, drv_s2_r, pin_val;
    logic [CW-1:0] por_cnt_r;
    logic [PW-1:0] prog_cnt_r;
    pcts_pkg::pcts_prog_e prog_r;
    logic wr_en, rd_en, prog_start;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign prog_start = wr_en && paddr == pcts_pkg::CTRL_OFF
                        && pwdata[pcts_pkg::CTRL_PROG_BIT] && prog_r == pcts_pkg::PCTS_IDLE;

    // pin synchroniser; level and drive flag each pass two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_s1_r <= '1;
            in_s2_r <= '1;
            drv_s1_r <= '1;
            drv_s2_r <= '1;
        end else begin
            in_s1_r <= in_pin;
            in_s2_r <= in_s1_r;
            drv_s1_r <= in_pin_driven;
            drv_s2_r <= drv_s1_r;
        end
    end

    // undriven pins read as one like a pull-up
    assign pin_val = in_s2_r | ~drv_s2_r;

    // power-up reset counter, done within the bounded time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_cnt_r <= '0;
            reset_done <= 1'b0;
        end else if (por_cnt_r != CW'(pcts_pkg::TPR_CYCLES - 1)) begin
            por_cnt_r <= por_cnt_r + 1'b1;
        end else begin
            reset_done <= 1'b1;
        end
    end

    // programming sequencer: erase phase then write phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_r <= pcts_pkg::PCTS_IDLE;
            prog_cnt_r <= '0;
        end else begin
            case (prog_r)
                pcts_pkg::PCTS_IDLE: begin
                    prog_cnt_r <= '0;
                    if (prog_start) begin
                        prog_r <= pcts_pkg::PCTS_ERASE;
                    end
                end
                pcts_pkg::PCTS_ERASE: begin
                    prog_cnt_r <= prog_cnt_r + 1'b1;
                    if (prog_cnt_r == PW'(pcts_pkg::ERASE_CYCLES - 1)) begin
                        prog_r <= pcts_pkg::PCTS_WRITE;
                    end
                end
                pcts_pkg::PCTS_WRITE: begin
                    prog_cnt_r <= prog_cnt_r + 1'b1;
                    if (prog_cnt_r == PW'(pcts_pkg::ERASE_CYCLES + pcts_pkg::WRITE_CYCLES - 1)) begin
                        prog_r <= pcts_pkg::PCTS_IDLE;
                    end
                end
                default: prog_r <= pcts_pkg::PCTS_IDLE;
            endcase
        end
    end

    // staging words written by software, committed by programming cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_lo_r <= pcts_pkg::SIG_RESET;
            stage_hi_r <= pcts_pkg::SIG_RESET;
            stage_cfg_r <= '0;
            lock_req_r <= 1'b0;
        end else if (wr_en && prog_r == pcts_pkg::PCTS_IDLE) begin
            if (paddr == pcts_pkg::SIG_LO_OFF) stage_lo_r <= pwdata;
            if (paddr == pcts_pkg::SIG_HI_OFF) stage_hi_r <= pwdata;
            if (paddr == pcts_pkg::CFG_OFF) stage_cfg_r <= pwdata;
            if (paddr == pcts_pkg::CTRL_OFF) lock_req_r <= pwdata[pcts_pkg::CTRL_LOCK_BIT];
        end
    end

    // stored array: erased then written; lock cleared only here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sig_lo_r <= pcts_pkg::SIG_RESET;
            sig_hi_r <= pcts_pkg::SIG_RESET;
            cfg_r <= '0;
            lock_r <= 1'b0;
        end else if (prog_r == pcts_pkg::PCTS_ERASE) begin
            sig_lo_r <= '0;
            sig_hi_r <= '0;
            cfg_r <= '0;
            lock_r <= 1'b0;
        end else if (prog_r == pcts_pkg::PCTS_WRITE) begin
            sig_lo_r <= stage_lo_r;
            sig_hi_r <= stage_hi_r;
            cfg_r <= stage_cfg_r;
            lock_r <= lock_req_r;
        end
    end

    // output configuration and one-shot preload request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pol_r <= '0;
            oe_r <= '0;
            preload_val_r <= '0;
            preload_r <= 1'b0;
        end else begin
            preload_r <= wr_en && paddr == pcts_pkg::CTRL_OFF
                         && pwdata[pcts_pkg::CTRL_PRELOAD_BIT];
            if (wr_en && paddr == pcts_pkg::POL_OFF) pol_r <= pwdata[NOUT-1:0];
            if (wr_en && paddr == pcts_pkg::OE_OFF) oe_r <= pwdata[NOUT-1:0];
            if (wr_en && paddr == pcts_pkg::PRELOAD_OFF) preload_val_r <= pwdata[NOUT-1:0];
        end
    end

    // macrocell bank; d from synced inputs, clear term from synced pins 0 and 1 until reset_done, set term tied low
    genvar g;
    generate
        for (g = 0; g < NOUT; g++) begin : g_cell
            pcts_macrocell u_cell (
                .pclk(pclk),
                .presetn(presetn),
                .d(pin_val[g % NIN]),
                .invert(pol_r[g]),
                .preload_en(preload_r),
                .preload_val(preload_val_r[g]),
                .async_clear_term(pin_val[0] & pin_val[1] & ~reset_done),
                .sync_set_term(1'b0),
                .q(mcell_q[g]),
                .pin_level(pin_lvl[g])
            );
        end
    endgenerate

    // registered pin drivers with polarity applied
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_pin_o <= '0;
            out_pin_oe <= '0;
        end else begin
            out_pin_o <= pin_lvl;
            out_pin_oe <= oe_r;
        end
    end

    // apb read data; signature always readable, config hidden when locked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= '0;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    pcts_pkg::SIG_LO_OFF: prdata <= sig_lo_r;
                    pcts_pkg::SIG_HI_OFF: prdata <= sig_hi_r;
                    pcts_pkg::CFG_OFF: begin
                        prdata <= lock_r ? pcts_pkg::LOCKED_READ_VALUE : cfg_r;
                        pslverr <= lock_r;
                    end
                    pcts_pkg::CTRL_OFF: prdata <= {30'h0, lock_req_r, 1'b0};
                    pcts_pkg::STAT_OFF: prdata <= {29'h0, reset_done,
                        prog_r != pcts_pkg::PCTS_IDLE, lock_r};
                    pcts_pkg::PRELOAD_OFF: prdata <= 32'(preload_val_r);
                    pcts_pkg::POL_OFF: prdata <= 32'(pol_r);
                    pcts_pkg::OE_OFF: prdata <= 32'(oe_r);
                    pcts_pkg::PIN_OFF: prdata <= 32'(pin_val);
                    pcts_pkg::MCELL_OFF: prdata <= 32'(mcell_q);
                    default: pslverr <= 1'b1;
                endcase
            end else if (psel && !penable) begin
                case (paddr)
                    pcts_pkg::SIG_LO_OFF, pcts_pkg::SIG_HI_OFF, pcts_pkg::CFG_OFF,
                    pcts_pkg::CTRL_OFF, pcts_pkg::PRELOAD_OFF, pcts_pkg::POL_OFF,
                    pcts_pkg::OE_OFF: pslverr <= 1'b0;
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule

// file: verification/pcts_top_chk.sv
// pcts_top_chk: port-level checks on pcts_top, bound at the foot.
// assumes apb requests are held until pready, as the bus demands.
`timescale 1ns/1ps
module pcts_chk #(
    parameter int NOUT = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NOUT-1:0] out_pin_o,
    input wire logic [NOUT-1:0] out_pin_oe,
    input wire logic reset_done
);
    logic [5:0] rcnt_r;
    logic [NOUT-1:0] pl_r;
    logic [NOUT-1:0] pol_r;
    logic wr;
    logic oe_wr;
    assign wr = psel && penable && pready && pwrite;
    assign oe_wr = wr && paddr == pcts_pkg::OE_OFF;
    // edges since release, and shadows of preload and polarity writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rcnt_r <= 6'h00;
            pl_r <= '0;
            pol_r <= '0;
        end else begin
            if (rcnt_r != 6'h3f) rcnt_r <= rcnt_r + 6'h01;
            if (wr && paddr == pcts_pkg::PRELOAD_OFF) pl_r <= pwdata[NOUT-1:0];
            if (wr && paddr == pcts_pkg::POL_OFF) pol_r <= pwdata[NOUT-1:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_ANSWER: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    AST_SIG_OK: assert property (pready && !pwrite && paddr <= 8'h04 |-> !pslverr)
        else $error("signature read refused");
    AST_LOCK_VALUE: assert property (pready && pslverr && paddr == pcts_pkg::CFG_OFF
        |-> prdata == pcts_pkg::LOCKED_READ_VALUE) else $error("locked read leaks data");
    AST_ERR_QUAL: assert property (pslverr |-> pready && psel && penable)
        else $error("error outside access phase");
    AST_RST_EARLY: assert property (rcnt_r < 6'h14 |-> !reset_done)
        else $error("reset done too early");
    AST_RST_BOUND: assert property (rcnt_r > 6'h13 |-> reset_done)
        else $error("reset done too late");
    AST_OE_HOLD: assert property ($changed(out_pin_oe) |-> $past(oe_wr, 2))
        else $error("enables moved without a write");
    AST_PRELOAD: assert property (wr && paddr == pcts_pkg::CTRL_OFF
        && pwdata[pcts_pkg::CTRL_PRELOAD_BIT]
        |-> ##[1:4] out_pin_o == (pl_r ^ pol_r)) else $error("preload missed the pins");
    cover property (pready && pslverr && paddr == pcts_pkg::CFG_OFF);
    cover property ($rose(reset_done));
    cover property (wr && paddr == pcts_pkg::CTRL_OFF && pwdata[2]);
endmodule
bind pcts_top pcts_chk #(.NOUT(NOUT)) chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .out_pin_o(out_pin_o), .out_pin_oe(out_pin_oe),
    .reset_done(reset_done));

// file: verification/pcts_pin_model.sv
// pcts_pin_model: outside pins, each driven to a level or left floating.
// assumes level and drive change just after rising pclk edges.
`timescale 1ns/1ps
module pcts_pin_model (
    input wire logic pclk,
    input wire logic [11:0] level,
    input wire logic [11:0] drive,
    output logic [11:0] in_pin,
    output logic [11:0] in_pin_driven
);
    logic [11:0] junk_r = 12'h000;
    // floating pins carry a toggling pattern, never a held value
    always_ff @(posedge pclk) junk_r <= ~junk_r;
    assign in_pin = (level & drive) | (junk_r & ~drive);
    assign in_pin_driven = drive;
endmodule

// file: verification/pld_config_test_support_bench.sv
// pld_config_test_support_bench: register-level scenarios for pcts_top.
// assumes pcts_pin_model drives the pins and the checker is bound.
`timescale 1ns/1ps
module pld_config_test_support_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, reset_done, er;
    logic [11:0] lvl = 12'h000;
    logic [11:0] drv = 12'hfff;
    logic [11:0] in_pin, in_pin_driven, out_pin_o, out_pin_oe;
    int fails = 0;
    int n_checks = 0;
    always #25 pclk = ~pclk;
    pcts_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_pin(in_pin), .in_pin_driven(in_pin_driven),
        .out_pin_o(out_pin_o), .out_pin_oe(out_pin_oe), .reset_done(reset_done));
    pcts_pin_model pins (.pclk(pclk), .level(lvl), .drive(drv), .in_pin(in_pin),
        .in_pin_driven(in_pin_driven));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // one apb transfer; answer taken at the rising edge that samples pready high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 50) begin
            fails++;
            complete_run();
        end else begin
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0);
        check(rd, e);
        check({31'h0, er}, {31'h0, ee});
    endtask
    // polls the busy flag until a programming cycle ends
    task automatic wait_prog;
        int n;
        for (n = 0; n < 40; n++) begin
            apb(1'b0, pcts_pkg::STAT_OFF, 32'h0);
            if (rd[pcts_pkg::STAT_BUSY_BIT] === 1'b0) break;
        end
        if (n == 40) begin
            fails++;
            complete_run();
        end
    endtask
    task automatic t_power;
        @(negedge pclk);
        check({31'h0, reset_done}, 32'h0);
        repeat (22) @(posedge pclk);
        rd_chk(pcts_pkg::STAT_OFF, 32'h4, 1'b0);
        check({20'h0, out_pin_o}, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check({31'h0, er}, 32'h1);
        $display("t_power done");
    endtask
    task automatic t_program;
        apb(1'b1, pcts_pkg::SIG_LO_OFF, 32'h1234_5678);
        apb(1'b1, pcts_pkg::SIG_HI_OFF, 32'h9abc_def0);
        apb(1'b1, pcts_pkg::CFG_OFF, 32'h0000_0f0f);
        apb(1'b1, pcts_pkg::CTRL_OFF, 32'h1);
        wait_prog();
        rd_chk(pcts_pkg::SIG_LO_OFF, 32'h1234_5678, 1'b0);
        rd_chk(pcts_pkg::SIG_HI_OFF, 32'h9abc_def0, 1'b0);
        rd_chk(pcts_pkg::CFG_OFF, 32'h0000_0f0f, 1'b0);
        $display("t_program done");
    endtask
    task automatic t_lock;
        apb(1'b1, pcts_pkg::CFG_OFF, 32'h0000_0aa5);
        apb(1'b1, pcts_pkg::CTRL_OFF, 32'h3);
        rd_chk(pcts_pkg::SIG_LO_OFF, 32'h0, 1'b0);
        wait_prog();
        rd_chk(pcts_pkg::STAT_OFF, 32'h5, 1'b0);
        rd_chk(pcts_pkg::CFG_OFF, pcts_pkg::LOCKED_READ_VALUE, 1'b1);
        rd_chk(pcts_pkg::SIG_HI_OFF, 32'h9abc_def0, 1'b0);
        apb(1'b1, pcts_pkg::CFG_OFF, 32'h0000_0333);
        apb(1'b1, pcts_pkg::CTRL_OFF, 32'h1);
        wait_prog();
        rd_chk(pcts_pkg::STAT_OFF, 32'h4, 1'b0);
        rd_chk(pcts_pkg::CFG_OFF, 32'h0000_0333, 1'b0);
        $display("t_lock done");
    endtask
    task automatic t_pins;
        logic seen;
        seen = 1'b0;
        lvl <= 12'h0f0;
        drv <= 12'hff0;
        apb(1'b1, pcts_pkg::POL_OFF, 32'h0000_000f);
        apb(1'b1, pcts_pkg::OE_OFF, 32'h0000_0fff);
        rd_chk(pcts_pkg::MCELL_OFF, 32'h0000_00ff, 1'b0);
        @(negedge pclk);
        check({20'h0, out_pin_o}, 32'h0000_00f0);
        check({20'h0, out_pin_oe}, 32'h0000_0fff);
        apb(1'b1, pcts_pkg::PRELOAD_OFF, 32'h0000_0a5a);
        apb(1'b1, pcts_pkg::CTRL_OFF, 32'h4);
        repeat (5) begin
            @(negedge pclk);
            if (out_pin_o === 12'ha55) seen = 1'b1;
        end
        check({31'h0, seen}, 32'h1);
        $display("t_pins done");
    endtask
    // clock keeps running; requests wait until reset has settled
    initial begin
        repeat (12) @(posedge pclk); // inputs stand still under reset
        presetn <= 1'b1;
        t_power();
        t_program();
        t_lock();
        t_pins();
        complete_run();
    end
endmodule
